// *** common/pec_pkg.sv ***
package pec_pkg;
   // register addresses in the management space
   localparam logic [4:0] PEC_ADDR_STAT_TWO = 5'h13;
   localparam logic [4:0] PEC_ADDR_FALSE_CARRIER = 5'h14;
   localparam logic [4:0] PEC_ADDR_RX_ERROR = 5'h15;
   localparam logic [4:0] PEC_ADDR_STAT_ONE = 5'h12;
   localparam logic [4:0] PEC_ADDR_IRQ_STATUS = 5'h1a;
   localparam logic [4:0] PEC_ADDR_IRQ_MASK = 5'h1b;
   // status bit positions, second status register
   localparam int PEC_BIT_UNDERVOLT = 15;
   localparam int PEC_BIT_OVERVOLT = 14;
   localparam int PEC_BIT_OVERTEMP = 11;
   localparam int PEC_BIT_SLEEP = 10;
   localparam int PEC_BIT_POLARITY = 9;
   localparam int PEC_BIT_JABBER = 8;
   // half-full bits, first status register
   localparam int PEC_BIT_FC_HALF = 9;
   localparam int PEC_BIT_RE_HALF = 8;
   // enables sit eight below their status bit
   localparam int PEC_EN_SHIFT = 8;
   // writable enable bits of each register
   localparam logic [15:0] PEC_EN_MASK_TWO = 16'h00cf;
   localparam logic [15:0] PEC_EN_MASK_ONE = 16'h0003;
   // counter limits and thresholds
   localparam logic [7:0] PEC_FC_MAX = 8'hff;
   localparam logic [7:0] PEC_FC_HALF = 8'h7f;
   localparam logic [15:0] PEC_RE_MAX = 16'hffff;
   localparam logic [15:0] PEC_RE_HALF = 16'h7fff;
   localparam logic [15:0] PEC_RESET_VAL = 16'h0000;
   // summary interrupt layout: bit 0 second status, bit 1 first status
   localparam logic [1:0] PEC_IRQ_LAYOUT = 2'h3;

   // register bus request
   typedef struct packed {
      logic [4:0] addr;
      logic [15:0] wdata;
      logic wr;
      logic rd;
   } pec_req_s;

   // raw event inputs, one per status bit
   typedef struct packed {
      logic undervolt;
      logic overvolt;
      logic overtemp;
      logic sleep;
      logic polarity;
      logic jabber;
   } pec_evt_s;
endpackage

// *** hw/pec_event_counters.sv ***
// The strobed register port was decided locally.
`timescale 1ns/100ps
module pec_event_counters
   import pec_pkg::*;
(
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_b,
   // register port
   input wire pec_req_s req,
   output logic [15:0] rdata,
   // event sources
   input wire pec_evt_s evt,
   input wire logic false_carrier,
   input wire logic rx_dv,
   input wire logic rx_symbol_err,
   input wire logic xmii_loopback,
   // interrupt
   output logic irq
);

   logic [15:0] stat_two;
   logic [15:0] stat_one;
   logic [7:0] latch_two;
   logic [7:0] en_two;
   logic [7:0] latch_one;
   logic [7:0] en_one;
   logic [7:0] fc_count;
   logic [15:0] re_count;
   logic [1:0] irq_status;
   logic [1:0] irq_mask;
   logic [15:0] ev_two;
   logic [15:0] ev_one;
   logic rd_two;
   logic rd_one;
   logic rd_fc;
   logic rd_re;
   logic rd_irq;
   logic re_inc;
   logic [1:0] pend;
   logic [15:0] next_rdata;

   // read strobes per clear-on-read register
   assign rd_two = req.rd && req.addr == PEC_ADDR_STAT_TWO;
   assign rd_one = req.rd && req.addr == PEC_ADDR_STAT_ONE;
   assign rd_fc = req.rd && req.addr == PEC_ADDR_FALSE_CARRIER;
   assign rd_re = req.rd && req.addr == PEC_ADDR_RX_ERROR;
   assign rd_irq = req.rd && req.addr == PEC_ADDR_IRQ_STATUS;

   // event vector in the status layout
   always_comb
   begin
      ev_two = 16'h0000;
      ev_two[PEC_BIT_UNDERVOLT] = evt.undervolt;
      ev_two[PEC_BIT_OVERVOLT] = evt.overvolt;
      ev_two[PEC_BIT_OVERTEMP] = evt.overtemp;
      ev_two[PEC_BIT_SLEEP] = evt.sleep;
      ev_two[PEC_BIT_POLARITY] = evt.polarity;
      ev_two[PEC_BIT_JABBER] = evt.jabber;
      ev_one = 16'h0000;
      ev_one[PEC_BIT_FC_HALF] = fc_count > PEC_FC_HALF;
      ev_one[PEC_BIT_RE_HALF] = re_count > PEC_RE_HALF;
   end

   // latched status, second register; a live event wins over the read clear
   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
         latch_two <= PEC_RESET_VAL[15:8];
      else if (rd_two)
         latch_two <= ev_two[15:8];
      else
         latch_two <= latch_two | ev_two[15:8];
   end

   // enables, second register; reserved 5:4 never take a write
   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
         en_two <= PEC_RESET_VAL[7:0];
      else if (req.wr && req.addr == PEC_ADDR_STAT_TWO)
         en_two <= req.wdata[7:0] & PEC_EN_MASK_TWO[7:0];
   end

   // half-full latches, first register (only bits 9:8 live in this block)
   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
         latch_one <= PEC_RESET_VAL[15:8];
      else if (rd_one)
         latch_one <= ev_one[15:8];
      else
         latch_one <= latch_one | ev_one[15:8];
   end

   // half-full enables, first register
   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
         en_one <= PEC_RESET_VAL[7:0];
      else if (req.wr && req.addr == PEC_ADDR_STAT_ONE)
         en_one <= req.wdata[7:0] & PEC_EN_MASK_ONE[7:0];
   end

   // false carrier counter; a read clears it, an event in that cycle is dropped
   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
         fc_count <= PEC_RESET_VAL[7:0];
      else if (rd_fc)
         fc_count <= PEC_RESET_VAL[7:0];
      else if (false_carrier && fc_count != PEC_FC_MAX)
         fc_count <= fc_count + 8'h01;
   end

   assign re_inc = rx_dv && rx_symbol_err && !xmii_loopback;

   // receive error counter, saturating at full scale
   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
         re_count <= PEC_RESET_VAL;
      else if (rd_re)
         re_count <= PEC_RESET_VAL;
      else if (re_inc && re_count != PEC_RE_MAX)
         re_count <= re_count + 16'h0001;
   end

   // register images; halves kept apart so each has a single writer
   assign stat_two = {latch_two, en_two};
   assign stat_one = {latch_one, en_one};

   // pending per status register: latched and enabled
   assign pend[0] = |(stat_two[15:8] & stat_two[7:0]);
   assign pend[1] = |(stat_one[15:8] & stat_one[7:0]);

   // sticky summary status, cleared by read; new pending wins over the clear
   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
         irq_status <= 2'h0;
      else if (rd_irq)
         irq_status <= pend;
      else
         irq_status <= irq_status | pend;
   end

   // summary mask
   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
         irq_mask <= 2'h0;
      else if (req.wr && req.addr == PEC_ADDR_IRQ_MASK)
         irq_mask <= req.wdata[1:0] & PEC_IRQ_LAYOUT;
   end

   // interrupt output registered; one cycle behind the status
   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
         irq <= 1'b0;
      else
         irq <= |(irq_status & irq_mask);
   end

   // read mux; unmapped and reserved bits read zero
   always_comb
   begin
      next_rdata = 16'h0000;
      case (req.addr)
         PEC_ADDR_STAT_TWO: next_rdata = stat_two;
         PEC_ADDR_STAT_ONE: next_rdata = stat_one;
         PEC_ADDR_FALSE_CARRIER: next_rdata = {8'h00, fc_count};
         PEC_ADDR_RX_ERROR: next_rdata = re_count;
         PEC_ADDR_IRQ_STATUS: next_rdata = {14'h0000, irq_status};
         PEC_ADDR_IRQ_MASK: next_rdata = {14'h0000, irq_mask};
         default: next_rdata = 16'h0000;
      endcase
   end

   // read data valid only in the cycle after the strobe
   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
         rdata <= 16'h0000;
      else if (req.rd)
         rdata <= next_rdata;
      else
         rdata <= 16'h0000;
   end

   // named steps for counter checks
   sequence s_fc_step;
      !rd_fc && false_carrier && fc_count != PEC_FC_MAX;
   endsequence

   sequence s_re_step;
      !rd_re && re_inc && re_count != PEC_RE_MAX;
   endsequence

   // pending and enabled, mask not being rewritten in the same cycle
   sequence s_two_pend;
      pend[0] && irq_mask[0] && !(req.wr && req.addr == PEC_ADDR_IRQ_MASK);
   endsequence

   property p_uv_latch;
      @(posedge core_clk) disable iff (!rst_b) evt.undervolt |=> stat_two[PEC_BIT_UNDERVOLT];
   endproperty
   a_uv_latch: assert property (p_uv_latch) else $error("undervoltage not latched");

   property p_jab_hold;
      @(posedge core_clk) disable iff (!rst_b)
         stat_two[PEC_BIT_JABBER] && !rd_two |=> stat_two[PEC_BIT_JABBER];
   endproperty
   a_jab_hold: assert property (p_jab_hold) else $error("jabber bit lost");

   property p_fc_inc;
      @(posedge core_clk) disable iff (!rst_b) s_fc_step |=> fc_count == $past(fc_count) + 8'h01;
   endproperty
   a_fc_inc: assert property (p_fc_inc) else $error("false carrier count wrong");

   property p_fc_sat;
      @(posedge core_clk) disable iff (!rst_b) fc_count == PEC_FC_MAX && !rd_fc |=> fc_count == PEC_FC_MAX;
   endproperty
   a_fc_sat: assert property (p_fc_sat) else $error("false carrier wrapped");

   property p_rd_clear;
      @(posedge core_clk) disable iff (!rst_b) rd_re |=> re_count == 16'h0000;
   endproperty
   a_rd_clear: assert property (p_rd_clear) else $error("receive error not cleared");

   property p_loop_hold;
      @(posedge core_clk) disable iff (!rst_b) xmii_loopback && !rd_re |=> $stable(re_count);
   endproperty
   a_loop_hold: assert property (p_loop_hold) else $error("counted in loopback");

   property p_re_half;
      @(posedge core_clk) disable iff (!rst_b) re_count > PEC_RE_HALF |=> stat_one[PEC_BIT_RE_HALF];
   endproperty
   a_re_half: assert property (p_re_half) else $error("receive half-full missed");

   property p_irq;
      @(posedge core_clk) disable iff (!rst_b) s_two_pend |-> ##[1:2] irq;
   endproperty
   a_irq: assert property (p_irq) else $error("interrupt not raised");

   property p_ov_latch;
      @(posedge core_clk) disable iff (!rst_b)
         evt.overvolt |=> stat_two[PEC_BIT_OVERVOLT];
   endproperty
   a_ov_latch: assert property (p_ov_latch) else $error("overvoltage not latched");

   property p_ot_latch;
      @(posedge core_clk) disable iff (!rst_b)
         evt.overtemp |=> stat_two[PEC_BIT_OVERTEMP];
   endproperty
   a_ot_latch: assert property (p_ot_latch) else $error("overtemperature not latched");

   property p_sleep_latch;
      @(posedge core_clk) disable iff (!rst_b)
         evt.sleep |=> stat_two[PEC_BIT_SLEEP];
   endproperty
   a_sleep_latch: assert property (p_sleep_latch) else $error("sleep event not latched");

   property p_pol_latch;
      @(posedge core_clk) disable iff (!rst_b)
         evt.polarity |=> stat_two[PEC_BIT_POLARITY];
   endproperty
   a_pol_latch: assert property (p_pol_latch) else $error("polarity change not latched");

   property p_jab_latch;
      @(posedge core_clk) disable iff (!rst_b)
         evt.jabber |=> stat_two[PEC_BIT_JABBER];
   endproperty
   a_jab_latch: assert property (p_jab_latch) else $error("jabber not latched");

   property p_en_write;
      @(posedge core_clk) disable iff (!rst_b)
         req.wr && req.addr == PEC_ADDR_STAT_TWO |=> {8'h00, stat_two[7:0]} == ($past(req.wdata) & PEC_EN_MASK_TWO);
   endproperty
   a_en_write: assert property (p_en_write) else $error("enable write wrong");

   property p_en_hold;
      @(posedge core_clk) disable iff (!rst_b)
         !(req.wr && req.addr == PEC_ADDR_STAT_TWO) |=> $stable(stat_two[7:0]);
   endproperty
   a_en_hold: assert property (p_en_hold) else $error("enables changed without write");

   property p_fc_idle;
      @(posedge core_clk) disable iff (!rst_b)
         !false_carrier && !rd_fc |=> $stable(fc_count);
   endproperty
   a_fc_idle: assert property (p_fc_idle) else $error("false carrier counted without event");

   property p_fc_half;
      @(posedge core_clk) disable iff (!rst_b)
         fc_count > PEC_FC_HALF |=> stat_one[PEC_BIT_FC_HALF];
   endproperty
   a_fc_half: assert property (p_fc_half) else $error("false carrier half-full missed");

   property p_fc_clear;
      @(posedge core_clk) disable iff (!rst_b)
         rd_fc |=> fc_count == PEC_RESET_VAL[7:0];
   endproperty
   a_fc_clear: assert property (p_fc_clear) else $error("false carrier not cleared");

   property p_fc_read;
      @(posedge core_clk) disable iff (!rst_b)
         rd_fc |=> rdata == {8'h00, $past(fc_count)};
   endproperty
   a_fc_read: assert property (p_fc_read) else $error("false carrier read value wrong");

   property p_re_read;
      @(posedge core_clk) disable iff (!rst_b)
         rd_re |=> rdata == $past(re_count);
   endproperty
   a_re_read: assert property (p_re_read) else $error("receive error read value wrong");

   property p_re_inc;
      @(posedge core_clk) disable iff (!rst_b)
         s_re_step |=> re_count == $past(re_count) + 16'h0001;
   endproperty
   a_re_inc: assert property (p_re_inc) else $error("receive error count wrong");

   property p_re_gate;
      @(posedge core_clk) disable iff (!rst_b)
         !rx_dv && !rd_re |=> $stable(re_count);
   endproperty
   a_re_gate: assert property (p_re_gate) else $error("counted without data valid");

   property p_re_sat;
      @(posedge core_clk) disable iff (!rst_b)
         re_count == PEC_RE_MAX && !rd_re |=> re_count == PEC_RE_MAX;
   endproperty
   a_re_sat: assert property (p_re_sat) else $error("receive error wrapped");

   property p_half_en;
      @(posedge core_clk) disable iff (!rst_b)
         req.wr && req.addr == PEC_ADDR_STAT_ONE |=> {8'h00, stat_one[7:0]} == ($past(req.wdata) & PEC_EN_MASK_ONE);
   endproperty
   a_half_en: assert property (p_half_en) else $error("half-full enable write wrong");

   property p_two_clear;
      @(posedge core_clk) disable iff (!rst_b)
         rd_two && ev_two == 16'h0000 |=> stat_two[15:8] == 8'h00;
   endproperty
   a_two_clear: assert property (p_two_clear) else $error("status not cleared by read");

   property p_one_clear;
      @(posedge core_clk) disable iff (!rst_b)
         rd_one && ev_one == 16'h0000 |=> stat_one[15:8] == 8'h00;
   endproperty
   a_one_clear: assert property (p_one_clear) else $error("half-full status not cleared by read");

   property p_irq_high;
      @(posedge core_clk) disable iff (!rst_b)
         (irq_status & irq_mask) != 2'h0 |=> irq;
   endproperty
   a_irq_high: assert property (p_irq_high) else $error("interrupt missing");

   property p_irq_low;
      @(posedge core_clk) disable iff (!rst_b)
         (irq_status & irq_mask) == 2'h0 |=> !irq;
   endproperty
   a_irq_low: assert property (p_irq_low) else $error("interrupt without unmasked status");

   property p_unmapped;
      @(posedge core_clk) disable iff (!rst_b)
         req.rd && !(rd_two || rd_one || rd_fc || rd_re || rd_irq) && req.addr != PEC_ADDR_IRQ_MASK |=> rdata == 16'h0000;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

endmodule // pec_event_counters

// *** dv/pec_event_counters_test.sv ***
`timescale 1ns/100ps
module pec_event_counters_test
   import pec_pkg::*;
;
   // clock, reset and design ports
   logic core_clk;
   logic rst_b;
   pec_req_s req;
   logic [15:0] rdata;
   pec_evt_s evt;
   logic false_carrier;
   logic rx_dv;
   logic rx_symbol_err;
   logic xmii_loopback;
   logic irq;
   int error_cnt;
   int comparisons;
   int i;

   pec_event_counters uut (
      .core_clk(core_clk),
      .rst_b(rst_b),
      .req(req),
      .rdata(rdata),
      .evt(evt),
      .false_carrier(false_carrier),
      .rx_dv(rx_dv),
      .rx_symbol_err(rx_symbol_err),
      .xmii_loopback(xmii_loopback),
      .irq(irq)
   );

   // 20 MHz core clock
   initial
   begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end

   // verdict and end of run, also used when a wait runs out
   task automatic final_report;
      if (error_cnt == 0 && comparisons > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // one-cycle write strobe, called just after a rising edge
   task automatic reg_wr(input logic [4:0] addr, input logic [15:0] data);
      req.addr <= addr;
      req.wdata <= data;
      req.wr <= 1'b1;
      @(posedge core_clk);
      req.wr <= 1'b0;
   endtask

   // read data stands only in the cycle after the strobe, so sample mid-cycle
   task automatic reg_rd(input logic [4:0] addr, input logic [15:0] exp, input string name);
      req.addr <= addr;
      req.rd <= 1'b1;
      @(posedge core_clk);
      req.rd <= 1'b0;
      @(negedge core_clk);
      check(name, rdata, exp);
      @(posedge core_clk);
   endtask

   // bounded wait for the interrupt level
   task automatic wait_irq(input logic exp);
      repeat (8)
      begin
         @(negedge core_clk);
         if (irq === exp)
            break;
      end
      check("irq", {15'h0000, irq}, {15'h0000, exp});
      if (irq !== exp)
         final_report();
      else
         @(posedge core_clk);
   endtask

   // held level counts once per cycle; trailing edge avoids double assignment
   task automatic hold_fc(input int n);
      false_carrier <= 1'b1;
      repeat (n) @(posedge core_clk);
      false_carrier <= 1'b0;
      @(posedge core_clk);
   endtask

   task automatic hold_rx(input logic dv, input logic err, input logic lb, input int n);
      rx_dv <= dv;
      rx_symbol_err <= err;
      xmii_loopback <= lb;
      repeat (n) @(posedge core_clk);
      rx_dv <= 1'b0;
      rx_symbol_err <= 1'b0;
      xmii_loopback <= 1'b0;
      @(posedge core_clk);
   endtask

   // main sequence
   initial
   begin
      error_cnt = 0;
      comparisons = 0;
      rst_b = 1'b0;
      req = '0;
      evt = '0;
      false_carrier = 1'b0;
      rx_dv = 1'b0;
      rx_symbol_err = 1'b0;
      xmii_loopback = 1'b0;
      repeat (3) @(posedge core_clk);
      rst_b <= 1'b1;
      @(posedge core_clk);
      reg_rd(PEC_ADDR_STAT_TWO, 16'h0000, "stat_two reset");
      reg_rd(PEC_ADDR_FALSE_CARRIER, 16'h0000, "fc reset");
      reg_rd(PEC_ADDR_RX_ERROR, 16'h0000, "re reset");
      reg_rd(5'h1f, 16'h0000, "unmapped");
      // all events with enables off: bits latch, interrupt stays quiet
      reg_wr(PEC_ADDR_IRQ_MASK, 16'h0003);
      evt <= 6'h3f;
      @(posedge core_clk);
      evt <= '0;
      repeat (6) @(posedge core_clk);
      wait_irq(1'b0);
      reg_rd(PEC_ADDR_STAT_TWO, 16'hcf00, "all latched");
      reg_rd(PEC_ADDR_STAT_TWO, 16'h0000, "all cleared");
      reg_rd(PEC_ADDR_IRQ_STATUS, 16'h0000, "summary masked");
      // reserved enable bits must not stick
      reg_wr(PEC_ADDR_STAT_TWO, 16'hffff);
      reg_rd(PEC_ADDR_STAT_TWO, 16'h00cf, "enables");
      // each event alone: latch position, interrupt, clear on read
      for (i = 0; i < 6; i++)
      begin
         evt <= pec_evt_s'(6'h01 << i);
         @(posedge core_clk);
         evt <= '0;
         wait_irq(1'b1);
         reg_rd(PEC_ADDR_STAT_TWO, 16'h00cf | (16'h0100 << (i < 4 ? i : i + 2)), "event bit");
         reg_rd(PEC_ADDR_STAT_TWO, 16'h00cf, "event cleared");
         reg_rd(PEC_ADDR_IRQ_STATUS, 16'h0001, "summary");
         wait_irq(1'b0);
      end
      // false carrier: threshold boundary, clear on read, saturation
      hold_fc(127);
      reg_rd(PEC_ADDR_STAT_ONE, 16'h0000, "fc at half");
      hold_fc(1);
      repeat (3) @(posedge core_clk);
      reg_rd(PEC_ADDR_STAT_ONE, 16'h0200, "fc above half");
      reg_rd(PEC_ADDR_FALSE_CARRIER, 16'h0080, "fc count");
      reg_rd(PEC_ADDR_FALSE_CARRIER, 16'h0000, "fc cleared");
      hold_fc(300);
      reg_rd(PEC_ADDR_FALSE_CARRIER, 16'h00ff, "fc saturated");
      reg_rd(PEC_ADDR_STAT_ONE, 16'h0200, "fc half held");
      reg_rd(PEC_ADDR_STAT_ONE, 16'h0000, "fc half cleared");
      // receive errors: qualified by data valid, frozen in loopback
      hold_rx(1'b1, 1'b1, 1'b0, 5);
      reg_rd(PEC_ADDR_RX_ERROR, 16'h0005, "re count");
      hold_rx(1'b0, 1'b1, 1'b0, 6);
      hold_rx(1'b1, 1'b0, 1'b0, 4);
      reg_rd(PEC_ADDR_RX_ERROR, 16'h0000, "re unqualified");
      hold_rx(1'b1, 1'b1, 1'b1, 7);
      reg_rd(PEC_ADDR_RX_ERROR, 16'h0000, "re loopback");
      hold_rx(1'b1, 1'b1, 1'b0, 65540);
      reg_rd(PEC_ADDR_RX_ERROR, 16'hffff, "re saturated");
      reg_rd(PEC_ADDR_STAT_ONE, 16'h0100, "re above half");
      reg_rd(PEC_ADDR_RX_ERROR, 16'h0000, "re cleared");
      // first-register enables and the summary path, then mask gating
      reg_wr(PEC_ADDR_STAT_ONE, 16'hffff);
      reg_rd(PEC_ADDR_STAT_ONE, 16'h0003, "enables one");
      hold_fc(128);
      wait_irq(1'b1);
      reg_rd(PEC_ADDR_IRQ_STATUS, 16'h0002, "summary one");
      reg_rd(PEC_ADDR_IRQ_MASK, 16'h0003, "mask");
      reg_wr(PEC_ADDR_IRQ_MASK, 16'h0000);
      wait_irq(1'b0);
      // reset in mid-run returns counters and latches to zero
      rst_b <= 1'b0;
      repeat (2) @(posedge core_clk);
      rst_b <= 1'b1;
      @(posedge core_clk);
      reg_rd(PEC_ADDR_FALSE_CARRIER, 16'h0000, "fc after reset");
      reg_rd(PEC_ADDR_STAT_ONE, 16'h0000, "one after reset");
      reg_rd(PEC_ADDR_IRQ_STATUS, 16'h0000, "summary after reset");
      final_report();
   end
endmodule // pec_event_counters_test
